// >>> hdl/adc_cfg_pkg.sv
/*
  Constants, field layout, reset values and encodings for the converter's
  serial configuration and status register bank.
  Assumes an 8-bit register space with 5-bit offsets reached over a
  four-wire serial port sampled in the sys_clk domain.
*/
package adc_cfg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [4:0] OFS_MODE      = 5'h05;
  localparam logic [4:0] OFS_OUTCTL    = 5'h06;
  localparam logic [4:0] OFS_RED_LAST  = 5'h07;
  localparam logic [4:0] OFS_TEMP      = 5'h08;
  localparam logic [4:0] OFS_ERR       = 5'h09;
  localparam logic [4:0] OFS_RSVD      = 5'h0A;
  localparam logic [4:0] OFS_ID_FIRST  = 5'h17;
  localparam logic [4:0] OFS_ID_LAST   = 5'h1E;
  localparam logic [4:0] OFS_REV       = 5'h1F;

  localparam int RED_REGS = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int MODE_RSVD_BIT  = 5;
  localparam int MODE_SLEEP_BIT = 6;
  localparam int MODE_TEMP_BIT  = 7;
  localparam int FORCE_LSB      = 0;
  localparam int CURR_LSB       = 2;
  localparam int TERM_LSB       = 4;
  localparam int OMODE_LSB      = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] MODE_RST   = 8'h20;
  localparam logic [7:0] OUTCTL_RST = 8'h04;
  localparam logic [7:0] OTHER_RST  = 8'h00;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;

  // Temperature code minus this figure gives degrees Celsius
  localparam int TEMP_OFFSET_C = 78;

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame: 8 header bits {read, addr[6:0]} then 8 data bits
  localparam logic [2:0] LAST_BIT_IDX = 3'h7;
  localparam logic       RW_READ      = 1'b1;

  typedef enum logic [0:0] {
    SER_HDR  = 1'b0,
    SER_DATA = 1'b1
  } ser_state_t;

  typedef enum logic [1:0] {
    FORCE_OFF0 = 2'b00,
    FORCE_OFF1 = 2'b01,
    FORCE_LOW  = 2'b10,
    FORCE_HIGH = 2'b11
  } force_t;

  typedef enum logic [1:0] {
    TERM_NONE0 = 2'b00,
    TERM_NONE1 = 2'b01,
    TERM_200   = 2'b10,
    TERM_100   = 2'b11
  } term_t;

  typedef enum logic [1:0] {
    OMODE_SAMPLED = 2'b00,
    OMODE_TOGGLE  = 2'b01,
    OMODE_RAMP    = 2'b10,
    OMODE_MID     = 2'b11
  } omode_t;

  localparam logic [11:0] PAT_A     = 12'hAAA;
  localparam logic [11:0] PAT_B     = 12'h555;
  localparam logic [11:0] MID_SCALE = 12'h800;
  localparam logic [11:0] ALL_ONES  = 12'hFFF;
  localparam logic [11:0] ALL_ZERO  = 12'h000;

  function automatic logic [7:0] majority8(input logic [7:0] a,
                                           input logic [7:0] b,
                                           input logic [7:0] c);
    majority8 = (a & b) | (a & c) | (b & c);
  endfunction

  function automatic logic [7:0] red_reset(input logic [2:0] idx);
    if (idx == OFS_MODE[2:0])
      red_reset = MODE_RST;
    else if (idx == OFS_OUTCTL[2:0])
      red_reset = OUTCTL_RST;
    else
      red_reset = OTHER_RST;
  endfunction

endpackage

// >>> hdl/spi_serial_slave.sv
/*
  Serial port front end: decodes 16-bit frames into register writes and
  read addresses, and shifts read data out.
  Assumes spi_clk, spi_en_n and spi_din are synchronous to sys_clk and that
  each spi_clk level lasts at least two sys_clk cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_serial_slave
  import adc_cfg_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       spi_clk,
  input  wire logic       spi_en_n,
  input  wire logic       spi_din,
  input  wire logic [7:0] rd_data,
  output logic            spi_dout,
  output logic            wr_stb,
  output logic [6:0]      acc_addr,
  output logic [7:0]      wr_data
);

  ser_state_t  state_r;
  logic [2:0]  bit_cnt_r;
  logic [6:0]  shift_in_r;
  logic        rw_r;
  logic        clk_prev_r;
  logic        load_r;
  logic        first_fall_r;
  logic [7:0]  shift_out_r;
  logic        rise;
  logic        fall;

  assign rise     = spi_clk & ~clk_prev_r & ~spi_en_n;
  assign fall     = ~spi_clk & clk_prev_r & ~spi_en_n;
  assign spi_dout = shift_out_r[7];

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      clk_prev_r <= 1'b0;
    else
      clk_prev_r <= spi_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencing; deselect aborts a partial frame without writing
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r    <= SER_HDR;
      bit_cnt_r  <= 3'h0;
      shift_in_r <= 7'h00;
      rw_r       <= 1'b0;
      acc_addr   <= 7'h00;
      wr_data    <= 8'h00;
      wr_stb     <= 1'b0;
      load_r     <= 1'b0;
    end
    else
    begin
      wr_stb <= 1'b0;
      load_r <= 1'b0;
      if (spi_en_n)
      begin
        state_r   <= SER_HDR;
        bit_cnt_r <= 3'h0;
      end
      else if (rise)
      begin
        shift_in_r <= {shift_in_r[5:0], spi_din};
        bit_cnt_r  <= bit_cnt_r + 3'h1;
        case (state_r)
          SER_HDR:
          begin
            if (bit_cnt_r == LAST_BIT_IDX)
            begin
              state_r  <= SER_DATA;
              rw_r     <= shift_in_r[6];
              acc_addr <= {shift_in_r[5:0], spi_din};
              load_r   <= 1'b1;
            end
          end
          SER_DATA:
          begin
            if (bit_cnt_r == LAST_BIT_IDX)
            begin
              state_r <= SER_HDR;
              wr_data <= {shift_in_r, spi_din};
              wr_stb  <= (rw_r != RW_READ);
            end
          end
          default:
            state_r <= SER_HDR;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data: loaded once the address settles, first fall keeps the MSB
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_out_r  <= 8'h00;
      first_fall_r <= 1'b0;
    end
    else if (spi_en_n)
    begin
      shift_out_r  <= 8'h00;
      first_fall_r <= 1'b0;
    end
    else if (load_r)
    begin
      shift_out_r  <= (rw_r == RW_READ) ? rd_data : 8'h00;
      first_fall_r <= 1'b1;
    end
    else if (fall)
    begin
      if (first_fall_r)
        first_fall_r <= 1'b0;
      else
        shift_out_r <= {shift_out_r[6:0], 1'b0};
    end
  end

endmodule
`default_nettype wire

// >>> hdl/redundant_reg_store.sv
/*
  Triple-redundant store for the writable configuration registers 0x00-0x07
  with majority-voted read-back and a copy-mismatch flag.
  Assumes writes arrive as single-cycle strobes from the serial front end.
*/
`timescale 1ns/1ps
`default_nettype none
module redundant_reg_store
  import adc_cfg_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_idx,
  input  wire logic [7:0]  wr_data,
  output logic [63:0]      voted_regs,
  output logic             mismatch
);

  logic [7:0] copy_a_r [0:RED_REGS-1];
  logic [7:0] copy_b_r [0:RED_REGS-1];
  logic [7:0] copy_c_r [0:RED_REGS-1];
  logic       diff;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < RED_REGS; i++)
      begin
        copy_a_r[i] <= red_reset(3'(i));
        copy_b_r[i] <= red_reset(3'(i));
        copy_c_r[i] <= red_reset(3'(i));
      end
    end
    else if (wr_en)
    begin
      copy_a_r[wr_idx] <= wr_data;
      copy_b_r[wr_idx] <= wr_data;
      copy_c_r[wr_idx] <= wr_data;
    end
  end

  // Voting masks a single upset copy while the flag still reports it
  always_comb
  begin
    diff = 1'b0;
    for (int i = 0; i < RED_REGS; i++)
    begin
      voted_regs[i*8 +: 8] = majority8(copy_a_r[i], copy_b_r[i], copy_c_r[i]);
      diff = diff | (copy_a_r[i] != copy_b_r[i]) | (copy_a_r[i] != copy_c_r[i]);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      mismatch <= 1'b0;
    else
      mismatch <= diff;
  end

endmodule
`default_nettype wire

// >>> hdl/adc_config_status_registers.sv
/*
  Configuration and status register bank of the converter: mode and output
  driver control, temperature readout, redundancy error flag, die identifier
  and revision, plus the output driver level and pattern control they steer.
  Assumes serial port pins and sample data are synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Mode bit 6 at one puts the device to sleep, at zero keeps it active.
// - Mode bit 7 enables the temperature sensor, which keeps working during sleep.
// - Output control bits 1:0 pass data for 00/01, force all outputs low for 10, high for 11.
// - Output control bits 3:2 pick one of four drive current steps and reset to 01.
// - Output control bits 5:4 pick no termination for 00/01, 200 ohm for 10, 100 ohm for 11.
// - Output control bits 7:6 at 00 make the outputs carry sampled conversion data.
// - Register die_temperature_readout returns the temperature code, degrees Celsius being code minus 78.
// - Bit 0 of register redundancy_error_status flags any disagreement among copies of registers 0x00-0x07.
// - Upper bits of redundancy_error_status and all of reserved_status read zero and are written only with zeros.
// - Registers 0x17-0x1E are read-only and each hold one byte of the 64-bit die identifier.
// - Register 0x1F is read-only and returns the design revision code.
// - Host writes to the temperature, error and reserved status registers change nothing.
// - All registers are read over the serial port; only 0x00-0x07 are written over it.
module adc_config_status_registers
  import adc_cfg_pkg::*;
#(
  parameter logic [63:0] DIE_IDENT = 64'h0123456789ABCDEF, // Arbitrary value
  parameter logic [7:0]  DIE_REV   = 8'h01                 // Arbitrary value
)
(
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        spi_clk,
  input  wire logic        spi_en_n,
  input  wire logic        spi_din,
  output logic             spi_dout,
  input  wire logic [11:0] sample_data_in,
  input  wire logic [7:0]  temp_code_in,
  output logic [11:0]      data_out,
  output logic             data_clk_out,
  output logic             sleep_mode,
  output logic             temp_sensor_en,
  output logic [1:0]       drive_current_code,
  output logic             term_200_en,
  output logic             term_100_en
);

  logic        wr_stb;
  logic [6:0]  acc_addr;
  logic [7:0]  wr_data;
  logic [7:0]  rd_data;
  logic [63:0] voted_regs;
  logic        mismatch;
  logic        red_wr;
  logic [7:0]  mode_reg;
  logic [7:0]  outctl_reg;
  logic [7:0]  temp_r;
  logic [11:0] ramp_r;
  logic        toggle_r;
  force_t      force_sel;
  omode_t      omode_sel;
  term_t       term_sel;
  logic [11:0] data_nxt;
  logic        clk_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Serial access
  spi_serial_slave u_serial (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .spi_clk  (spi_clk),
    .spi_en_n (spi_en_n),
    .spi_din  (spi_din),
    .rd_data  (rd_data),
    .spi_dout (spi_dout),
    .wr_stb   (wr_stb),
    .acc_addr (acc_addr),
    .wr_data  (wr_data)
  );

  // Only 0x00-0x07 take writes; status and identity bytes ignore them
  assign red_wr = wr_stb && (acc_addr <= {2'b00, OFS_RED_LAST});

  redundant_reg_store u_store (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .wr_en      (red_wr),
    .wr_idx     (acc_addr[2:0]),
    .wr_data    (wr_data),
    .voted_regs (voted_regs),
    .mismatch   (mismatch)
  );

  assign mode_reg   = voted_regs[OFS_MODE[2:0]*8 +: 8];
  assign outctl_reg = voted_regs[OFS_OUTCTL[2:0]*8 +: 8];

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read zero
  always_comb
  begin
    rd_data = ZERO_BYTE;
    if (acc_addr[6:5] == 2'b00)
    begin
      if (acc_addr[4:0] <= OFS_RED_LAST)
        rd_data = voted_regs[acc_addr[2:0]*8 +: 8];
      else if (acc_addr[4:0] == OFS_TEMP)
        rd_data = temp_r;
      else if (acc_addr[4:0] == OFS_ERR)
        rd_data = {7'h00, mismatch};
      else if (acc_addr[4:0] == OFS_RSVD)
        rd_data = ZERO_BYTE;
      else if (acc_addr[4:0] >= OFS_ID_FIRST && acc_addr[4:0] <= OFS_ID_LAST)
        rd_data = DIE_IDENT[(acc_addr[4:0] - OFS_ID_FIRST)*8 +: 8];
      else if (acc_addr[4:0] == OFS_REV)
        rd_data = DIE_REV;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode controls
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sleep_mode     <= 1'b0;
      temp_sensor_en <= 1'b0;
    end
    else
    begin
      sleep_mode     <= mode_reg[MODE_SLEEP_BIT];
      temp_sensor_en <= mode_reg[MODE_TEMP_BIT];
    end
  end

  // Sensor readout ignores sleep so it can be polled while asleep
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      temp_r <= ZERO_BYTE;
    else if (mode_reg[MODE_TEMP_BIT])
      temp_r <= temp_code_in;
    else
      temp_r <= ZERO_BYTE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Driver strength and termination
  assign term_sel = term_t'(outctl_reg[TERM_LSB +: 2]);

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      drive_current_code <= OUTCTL_RST[CURR_LSB +: 2];
      term_200_en        <= 1'b0;
      term_100_en        <= 1'b0;
    end
    else
    begin
      drive_current_code <= outctl_reg[CURR_LSB +: 2];
      term_200_en        <= (term_sel == TERM_200);
      term_100_en        <= (term_sel == TERM_100);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output data path: force beats sleep, sleep beats the output mode
  assign force_sel = force_t'(outctl_reg[FORCE_LSB +: 2]);
  assign omode_sel = omode_t'(outctl_reg[OMODE_LSB +: 2]);

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ramp_r   <= ALL_ZERO;
      toggle_r <= 1'b0;
    end
    else
    begin
      ramp_r   <= ramp_r + 12'h001;
      toggle_r <= ~toggle_r;
    end
  end

  always_comb
  begin
    data_nxt = ALL_ZERO;
    clk_nxt  = 1'b0;
    case (force_sel)
      FORCE_LOW:
      begin
        data_nxt = ALL_ZERO;
        clk_nxt  = 1'b0;
      end
      FORCE_HIGH:
      begin
        data_nxt = ALL_ONES;
        clk_nxt  = 1'b1;
      end
      default:
      begin
        if (!mode_reg[MODE_SLEEP_BIT])
        begin
          clk_nxt = ~toggle_r;
          case (omode_sel)
            OMODE_SAMPLED: data_nxt = sample_data_in;
            OMODE_TOGGLE:  data_nxt = toggle_r ? PAT_B : PAT_A;
            OMODE_RAMP:    data_nxt = ramp_r;
            OMODE_MID:     data_nxt = MID_SCALE;
            default:       data_nxt = ALL_ZERO;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      data_out     <= ALL_ZERO;
      data_clk_out <= 1'b0;
    end
    else
    begin
      data_out     <= data_nxt;
      data_clk_out <= clk_nxt;
    end
  end

endmodule
`default_nettype wire

// >>> testbench/adc_cfg_checker.sv
/*
  Port-level assertions for the configuration and status register bank.
  Assumes one clock domain and binding onto adc_config_status_registers.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_cfg_checker
  import adc_cfg_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        spi_en_n,
  input wire logic        spi_dout,
  input wire logic [11:0] data_out,
  input wire logic        data_clk_out,
  input wire logic        sleep_mode,
  input wire logic        temp_sensor_en,
  input wire logic [1:0]  drive_current_code,
  input wire logic        term_200_en,
  input wire logic        term_100_en
);
  logic [3:0] idle_cnt_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////
  // Cycles since select was last low; settings may only move near a frame
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      idle_cnt_r <= 4'h0;
    else if (!spi_en_n)
      idle_cnt_r <= 4'h0;
    else if (idle_cnt_r != 4'hF)
      idle_cnt_r <= idle_cnt_r + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_RST_VALUES: assert property (!$past(reset_n) |-> drive_current_code == 2'b01
    && !sleep_mode && !temp_sensor_en && !term_200_en && !term_100_en)
    else $error("settings wrong after reset");
  AST_FORCE_HIGH: assert property (data_clk_out [*3] |-> $past(data_out) == ALL_ONES)
    else $error("clock held high without all-ones data");
  AST_FORCE_LOW: assert property ((!data_clk_out) [*3] |-> $past(data_out) == ALL_ZERO)
    else $error("clock held low without all-zero data");
  AST_SLEEP_DATA: assert property ($rose(sleep_mode) |-> ##[0:2]
    (data_out == ALL_ZERO || data_out == ALL_ONES))
    else $error("data still live in sleep");
  AST_SLEEP_CLK: assert property (sleep_mode [*3] ##0 (idle_cnt_r > 4'h8)
    |-> $stable(data_clk_out))
    else $error("output clock runs in sleep");
  AST_DOUT_IDLE: assert property (spi_en_n [*3] |-> !spi_dout)
    else $error("serial out active while deselected");
  AST_MODE_QUIET: assert property ($changed(sleep_mode) || $changed(temp_sensor_en)
    |-> idle_cnt_r < 4'h8)
    else $error("mode outputs moved without a frame");
  AST_DRV_QUIET: assert property ($changed({drive_current_code, term_200_en, term_100_en})
    |-> idle_cnt_r < 4'h8)
    else $error("driver settings moved without a frame");
  AST_TERM_EXCL: assert property (!(term_200_en && term_100_en))
    else $error("both terminations on");

  cover property (data_clk_out [*3]);
  cover property (sleep_mode && temp_sensor_en);
  cover property ($fell(spi_en_n) ##[1:200] spi_dout);
endmodule
bind adc_config_status_registers adc_cfg_checker u_adc_cfg_checker (
  .sys_clk(sys_clk), .reset_n(reset_n), .spi_en_n(spi_en_n), .spi_dout(spi_dout),
  .data_out(data_out), .data_clk_out(data_clk_out), .sleep_mode(sleep_mode),
  .temp_sensor_en(temp_sensor_en), .drive_current_code(drive_current_code),
  .term_200_en(term_200_en), .term_100_en(term_100_en));
`default_nettype wire

// >>> testbench/spi_host_model.sv
/*
  Behavioural serial host controller for the register bank.
  Assumes tasks are called from one process, just after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
  import adc_cfg_pkg::*;
(
  input  wire logic clk,
  input  wire logic spi_dout,
  output logic      spi_clk,
  output logic      spi_en_n,
  output logic      spi_din
);
  initial
  begin
    spi_clk  = 1'b0;
    spi_en_n = 1'b1;
    spi_din  = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Frame of nbits; fewer than 16 aborts it. Clock stands still outside frames
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd,
                      input int nbits, output logic [7:0] rdat);
    logic [15:0] frm;
    frm = {rd, a, wd};
    rdat = 8'h00;
    tick(1);
    spi_en_n = 1'b0;
    for (int i = 15; i >= 16 - nbits; i--)
    begin
      spi_din = frm[i];
      tick(2);
      if (i < 8)
        rdat = {rdat[6:0], spi_dout};
      spi_clk = 1'b1;
      tick(2);
      spi_clk = 1'b0;
    end
    tick(2);
    spi_en_n = 1'b1;
    // Released line must not look like held data
    spi_din = ~spi_din;
  endtask

  task automatic write_reg(input logic [6:0] a, input logic [7:0] v);
    logic [7:0] d;
    logic [7:0] unused;
    d = v;
    if (a == {2'b00, OFS_MODE})
      d[MODE_RSVD_BIT] = 1'b1;
    if (a == {2'b00, OFS_ERR} || a == {2'b00, OFS_RSVD})
      d = ZERO_BYTE;
    xfer(1'b0, a, d, 16, unused);
  endtask
endmodule
`default_nettype wire

// >>> testbench/adc_config_status_registers_tb.sv
/*
  Self-checking bench for the register bank: register traffic, output
  control, sleep and temperature paths.
  Assumes the host model drives the serial pins and the checker is bound.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module adc_config_status_registers_tb;
  import adc_cfg_pkg::*;
  localparam logic [63:0] TB_IDENT = 64'hF0E1D2C3B4A59687; // Arbitrary value
  localparam logic [7:0]  TB_REV   = 8'h3C;                // Arbitrary value
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  wire logic   spi_clk, spi_en_n, spi_din;
  logic        spi_dout, data_clk_out, sleep_mode, temp_sensor_en, term_200_en, term_100_en;
  logic [11:0] sample_data_in = 12'h000;
  logic [7:0]  temp_code_in = 8'h00;
  logic [11:0] data_out, smp_prev;
  logic [1:0]  drive_current_code;
  logic [7:0]  rdat, oc;
  int          error_cnt = 0;
  int          cmp_count = 0;
  logic [7:0]  corner [8] = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'h01, 8'h02, 8'h2B, 8'h3C};

  adc_config_status_registers #(.DIE_IDENT(TB_IDENT), .DIE_REV(TB_REV))
    u_adc_config_status_registers (.sys_clk(sys_clk), .reset_n(reset_n),
    .spi_clk(spi_clk), .spi_en_n(spi_en_n), .spi_din(spi_din), .spi_dout(spi_dout),
    .sample_data_in(sample_data_in), .temp_code_in(temp_code_in), .data_out(data_out),
    .data_clk_out(data_clk_out), .sleep_mode(sleep_mode), .temp_sensor_en(temp_sensor_en),
    .drive_current_code(drive_current_code), .term_200_en(term_200_en),
    .term_100_en(term_100_en));
  spi_host_model u_spi_host_model (.clk(sys_clk), .spi_dout(spi_dout), .spi_clk(spi_clk),
    .spi_en_n(spi_en_n), .spi_din(spi_din));

  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    #1;
    smp_prev = sample_data_in;
    sample_data_in = 12'($urandom);
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] exp_data(logic [7:0] c, logic slp, logic [11:0] smp,
                                           logic [11:0] po);
    if (c[1:0] == FORCE_LOW) return ALL_ZERO;
    if (c[1:0] == FORCE_HIGH) return ALL_ONES;
    if (slp) return ALL_ZERO;
    case (c[7:6])
      2'b00: return smp;
      2'b01: return (po == PAT_A) ? PAT_B : PAT_A;
      2'b10: return po + 12'h001;
      default: return MID_SCALE;
    endcase
  endfunction

  function automatic logic exp_clk(logic [7:0] c, logic slp, logic pc);
    if (c[1:0] == FORCE_LOW || c[1:0] == FORCE_HIGH) return c[0];
    return slp ? 1'b0 : ~pc;
  endfunction

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    u_spi_host_model.xfer(1'b1, {2'b00, a}, 8'h00, 16, d);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    u_spi_host_model.write_reg({2'b00, a}, v);
  endtask

  task automatic chk_path(input logic [7:0] c, input logic slp);
    logic [11:0] po;
    logic pc;
    repeat (3) @(posedge sys_clk);
    #2;
    for (int k = 0; k < 6; k++)
    begin
      po = data_out;
      pc = data_clk_out;
      @(posedge sys_clk);
      #2;
      `CHK(data_out, exp_data(c, slp, smp_prev, po))
      `CHK(data_clk_out, exp_clk(c, slp, pc))
    end
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(30000 * 50);
    error_cnt++;
    complete_run;
  end

  initial
  begin
    void'($urandom(32'hC2B92E5C));
    repeat (12) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    `CHK(drive_current_code, 2'b01)
    rd(OFS_MODE, rdat);
    `CHK(rdat, MODE_RST)
    rd(OFS_OUTCTL, rdat);
    `CHK(rdat, OUTCTL_RST)
    for (int i = 0; i < 9; i++)
    begin
      u_spi_host_model.xfer(1'b0, {2'b00, OFS_ID_FIRST + 5'(i)}, 8'(~i), 16, rdat);
      rd(OFS_ID_FIRST + 5'(i), rdat);
      `CHK(rdat, (i < 8) ? TB_IDENT[8*i +: 8] : TB_REV)
    end
    // Status places must not take writes; reserved ones only ever get zeros
    for (int j = 8; j < 11; j++)
    begin
      wr(5'(j), 8'hFF);
      rd(5'(j), rdat);
      `CHK(rdat, ZERO_BYTE)
    end
    for (int m = 0; m < 4; m++)
    begin
      temp_code_in = 8'($urandom);
      wr(OFS_MODE, {m[1], m[0], 6'h00});
      `CHK(sleep_mode, m[0])
      `CHK(temp_sensor_en, m[1])
      rd(OFS_MODE, rdat);
      `CHK(rdat, {m[1], m[0], 6'h20})
      rd(OFS_TEMP, rdat);
      `CHK(rdat, m[1] ? temp_code_in : ZERO_BYTE)
      chk_path(OUTCTL_RST, m[0]);
    end
    wr(OFS_MODE, 8'h00);
    for (int i = 0; i < 14; i++)
    begin
      oc = (i < 8) ? corner[i] : 8'($urandom);
      wr(OFS_OUTCTL, oc);
      rd(OFS_OUTCTL, rdat);
      `CHK(rdat, oc)
      `CHK(drive_current_code, oc[3:2])
      `CHK({term_200_en, term_100_en}, {oc[5:4] == 2'b10, oc[5:4] == 2'b11})
      chk_path(oc, 1'b0);
    end
    wr(OFS_MODE, 8'h40);
    wr(OFS_OUTCTL, 8'h03);
    chk_path(8'h03, 1'b1);
    wr(OFS_OUTCTL, OUTCTL_RST);
    u_spi_host_model.xfer(1'b0, {2'b00, OFS_OUTCTL}, 8'hFF, 10, rdat);
    rd(OFS_OUTCTL, rdat);
    `CHK(rdat, OUTCTL_RST)
    u_spi_host_model.xfer(1'b1, 7'h60, 8'h00, 16, rdat);
    `CHK(rdat, ZERO_BYTE)
    rd(OFS_ERR, rdat);
    `CHK(rdat, ZERO_BYTE)
    complete_run;
  end
endmodule
`default_nettype wire
